// file: logic/dmon_params.svh
`ifndef DMON_PARAMS_SVH
`define DMON_PARAMS_SVH
// register byte offsets
`define DMON_A_MONSEL 8'h00
`define DMON_A_ENCLR 8'h04
`define DMON_A_RTCLR 8'h08
`define DMON_A_DECSEL 8'h0c
`define DMON_A_FREF 8'h10
`define DMON_A_CREF 8'h14
`define DMON_A_MSRC 8'h18
`define DMON_A_ENRAW 8'h1c
`define DMON_A_ENCOM 8'h20
`define DMON_A_ENHRS 8'h24
`define DMON_A_RNHRS 8'h28
`define DMON_A_ENWRP 8'h2c
`define DMON_A_RNWRP 8'h30
`define DMON_A_SEG 8'h34
`define DMON_A_METER 8'h38
// monitor selection codes
`define DMON_SEL_ENHRS 8'h14
`define DMON_SEL_RNHRS 8'h17
`define DMON_SEL_ENERGY 8'h19
`define DMON_SEL_TERM 8'h37
`define DMON_SEL_OPTIN 8'h38
`define DMON_SEL_OPTOUT 8'h39
// parameter values
`define DMON_V_NOFUNC 16'h270f
`define DMON_V_TEN 16'h000a
`define DMON_V_ZERO 16'h0000
`define DMON_V_ONE 16'h0001
`define DMON_V_10K 32'h0000_2710
// energy display thresholds, 0.01 kWh units; the two MAX caps in whole kWh
`define DMON_E_4D2 32'h0000_270f
`define DMON_E_4D1 32'h0001_869f
`define DMON_E_5D2 32'h0001_869f
`define DMON_E_5D1 32'h000f_423f
`define DMON_E_4MAX 24'h00_270f
`define DMON_E_5MAX 24'h0f_423f
// full-scale references, 0.01 unit steps; last is the full-scale meter code
`define DMON_FREF_RST 16'h1388
`define DMON_FREF_MAX 16'h9c40
`define DMON_CREF_MAX 16'hc350
`define DMON_METER_FS 10'h3e8
`endif

// file: logic/dmon_pkg.sv
package dmon_pkg;
   typedef logic [15:0] dmon_hours_t;
   typedef logic [31:0] dmon_word_t;
   typedef logic [9:0] dmon_meter_t;
   typedef logic [31:0] dmon_seg_t;
endpackage

// file: logic/dmon_monitor.sv
// Behaviour
// - selections 55 to 57 put the terminal monitor in the third position
// - segment lit when terminal active, dark otherwise; centre row always lit
// - selection 55: own inputs on upper segments, outputs on lower
// - 56 shows option inputs, first dp lit; 57 option outputs, second dp
// - 56 and 57 accepted without option; then terminal segments dark, centre row and its dp still lit
// - energy adds output power, reported total refreshed once per hour
// - four-digit energy: 0.01 to 99.99, 0.1 to 999.9, 1 to 9999
// - five-digit energy: 0.01 to 999.99, then 0.1, then 1 to 999999
// - comm energy in kWh: 0-65535 at 9999, 0-9999 at 10
// - after clearing write, energy clear parameter reads 9999 or 10
// - energization hours counted from first power-up
// - run hours counted only while running, held while stopped
// - hour counters wrap 65535 to 0; each wrap bumps its own count
// - writing 0 to run clear zeroes run hours; no energize clear
// - run hour added only after a full continuous running hour
// - run clear parameter reads 9999; writing 9999 changes nothing
// - decimal select 0 rounds fractional monitors, below 0.99 shows 0
// - decimal select 1 drops hundredths; integers unchanged
// - decimal select leaves hour and energy monitors unchanged
// - frequency reference 0-400 Hz, default 50, maps to full meter code
// - current reference 0-500 A, default rated, maps to full meter code
`timescale 1ns/1ps
`default_nettype none
`include "dmon_params.svh"
module dmon_monitor #(
   parameter logic [15:0] RATED_CURRENT = 16'h0320,
   parameter int PWR_W = 16
) (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output dmon_pkg::dmon_word_t PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // drive state sources
   input wire logic HOUR_TICK_I,
   input wire logic RUNNING_I,
   input wire logic [PWR_W-1:0] POWER_I,
   input wire logic [15:0] FREQ_I,
   input wire logic [15:0] CURRENT_I,
   // generic monitor value
   input wire logic [23:0] MON_VALUE_I,
   input wire logic [1:0] MON_FRAC_I,
   // terminals
   input wire logic [11:0] IN_TERM_I,
   input wire logic [11:0] OUT_TERM_I,
   input wire logic OPT_IN_FIT_I,
   input wire logic [23:0] OPT_IN_TERM_I,
   input wire logic OPT_OUT_FIT_I,
   input wire logic [23:0] OPT_OUT_TERM_I,
   // display and meter
   output dmon_pkg::dmon_seg_t SEG_O,
   output logic TERM_MON_O,
   output logic [23:0] DISP_VALUE_O,
   output logic [1:0] DISP_FRAC_O,
   output logic [23:0] PU_VALUE_O,
   output logic [1:0] PU_FRAC_O,
   output dmon_pkg::dmon_meter_t METER_O
);
   import dmon_pkg::*;

   // power width must fit the 24-bit display path and the 32-bit sum
   if (PWR_W < 1 || PWR_W > 24) begin : g_bad_pwr
      $error("PWR_W out of range");
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // spreads 3 upper and 3 lower bits per digit, centre always lit
   function automatic dmon_seg_t seg_map(input logic [11:0] up,
                                         input logic [11:0] lo,
                                         input logic [1:0] dp);
      dmon_seg_t s;
      s = '0;
      for (int d = 0; d < 4; d++) begin
         s[d*8+0] = up[d*3+0];
         s[d*8+1] = up[d*3+1];
         s[d*8+5] = up[d*3+2];
         s[d*8+2] = lo[d*3+0];
         s[d*8+3] = lo[d*3+1];
         s[d*8+4] = lo[d*3+2];
         s[d*8+6] = 1'b1;
      end
      s[7] = dp[0];
      s[15] = dp[1];
      return s;
   endfunction

   // proportional meter code, saturating; zero reference pins full scale for any nonzero value
   function automatic dmon_meter_t scale(input logic [15:0] val,
                                         input logic [15:0] ref_v);
      logic [25:0] q;
      q = '0;
      if (ref_v == 16'h0000) begin
         return (val != 16'h0000) ? `DMON_METER_FS : 10'h000;
      end
      q = ({10'h000, val} * {16'h0000, `DMON_METER_FS}) / {10'h000, ref_v};
      if (q > {16'h0000, `DMON_METER_FS}) begin
         return `DMON_METER_FS;
      end
      return q[9:0];
   endfunction

   // clamps a written reference to its top value
   function automatic logic [15:0] clamp(input logic [15:0] v,
                                         input logic [15:0] mx);
      return (v > mx) ? mx : v;
   endfunction

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   logic [7:0] monitor_select;
   logic [15:0] energy_clear_param;
   logic [15:0] decimal_digit_select;
   logic [15:0] freq_fullscale_ref;
   logic [15:0] current_fullscale_ref;
   logic meter_src;
   logic [31:0] energy_acc;
   logic [31:0] energy_rep;
   dmon_hours_t energize_hrs;
   dmon_hours_t run_hrs;
   dmon_hours_t energize_wrap_count;
   dmon_hours_t runtime_wrap_count;
   logic run_full;
   logic [31:0] comm_energy;
   logic [31:0] rd_mux;
   logic hit;
   logic wr;
   logic [15:0] wd;

   assign wr = PSEL_I && PENABLE_I && PWRITE_I;
   assign wd = PWDATA_I[15:0];
   // always ready: every register answers in the access cycle
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = PSEL_I && PENABLE_I && !hit;

   // read mux; unmapped offsets read zero and flag an error
   always_comb begin
      hit = 1'b1;
      rd_mux = '0;
      unique case (PADDR_I)
         `DMON_A_MONSEL: rd_mux = {24'h000000, monitor_select};
         `DMON_A_ENCLR: rd_mux = {16'h0000, energy_clear_param};
         `DMON_A_RTCLR: rd_mux = {16'h0000, `DMON_V_NOFUNC};
         `DMON_A_DECSEL: rd_mux = {16'h0000, decimal_digit_select};
         `DMON_A_FREF: rd_mux = {16'h0000, freq_fullscale_ref};
         `DMON_A_CREF: rd_mux = {16'h0000, current_fullscale_ref};
         `DMON_A_MSRC: rd_mux = {31'h0, meter_src};
         `DMON_A_ENRAW: rd_mux = energy_rep;
         `DMON_A_ENCOM: rd_mux = comm_energy;
         `DMON_A_ENHRS: rd_mux = {16'h0000, energize_hrs};
         `DMON_A_RNHRS: rd_mux = {16'h0000, run_hrs};
         `DMON_A_ENWRP: rd_mux = {16'h0000, energize_wrap_count};
         `DMON_A_RNWRP: rd_mux = {16'h0000, runtime_wrap_count};
         `DMON_A_SEG: rd_mux = SEG_O;
         `DMON_A_METER: rd_mux = {22'h0, METER_O};
         default: hit = 1'b0;
      endcase
   end

   // read data is caught in the setup cycle so it is stable when sampled
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         PRDATA_O <= '0;
      end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
         PRDATA_O <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // parameter registers
   // ------------------------------------------------------------
   logic wr_enclr_zero;
   logic wr_rtclr_zero;
   assign wr_enclr_zero = wr && PADDR_I == `DMON_A_ENCLR && wd == `DMON_V_ZERO;
   assign wr_rtclr_zero = wr && PADDR_I == `DMON_A_RTCLR && wd == `DMON_V_ZERO;

   // settings written by software; unlisted clear and decimal values are ignored, references clamped
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         monitor_select <= 8'h00;
         energy_clear_param <= `DMON_V_NOFUNC;
         decimal_digit_select <= `DMON_V_NOFUNC;
         freq_fullscale_ref <= `DMON_FREF_RST;
         current_fullscale_ref <= RATED_CURRENT;
         meter_src <= 1'b0;
      end else if (wr) begin
         unique case (PADDR_I)
            // 56 and 57 accepted whether or not an option is fitted
            `DMON_A_MONSEL: monitor_select <= PWDATA_I[7:0];
            `DMON_A_ENCLR: begin
               // zero only clears; range selection is kept
               if (wd == `DMON_V_NOFUNC || wd == `DMON_V_TEN) begin
                  energy_clear_param <= wd;
               end
            end
            `DMON_A_DECSEL: begin
               if (wd == `DMON_V_NOFUNC || wd == `DMON_V_ZERO ||
                   wd == `DMON_V_ONE) begin
                  decimal_digit_select <= wd;
               end
            end
            `DMON_A_FREF: freq_fullscale_ref <= clamp(wd, `DMON_FREF_MAX);
            `DMON_A_CREF: current_fullscale_ref <= clamp(wd, `DMON_CREF_MAX);
            `DMON_A_MSRC: meter_src <= PWDATA_I[0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // energy accumulator
   // ------------------------------------------------------------
   // power in 0.01 kW summed once per hour gives 0.01 kWh steps
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         energy_acc <= '0;
      end else if (wr_enclr_zero) begin
         energy_acc <= '0;
      end else if (HOUR_TICK_I) begin
         energy_acc <= energy_acc + {{(32-PWR_W){1'b0}}, POWER_I};
      end
   end

   // reported total follows the accumulator only at the hour tick
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         energy_rep <= '0;
      end else if (wr_enclr_zero) begin
         energy_rep <= '0;
      end else if (HOUR_TICK_I) begin
         energy_rep <= energy_acc + {{(32-PWR_W){1'b0}}, POWER_I};
      end
   end

   // comm value in whole kWh, range set by the clear parameter
   always_comb begin
      logic [31:0] kwh;
      kwh = energy_rep / 32'h0000_0064;
      if (energy_clear_param == `DMON_V_TEN) begin
         comm_energy = kwh % `DMON_V_10K;
      end else begin
         comm_energy = {16'h0000, kwh[15:0]};
      end
   end

   // ------------------------------------------------------------
   // hour accumulators
   // ------------------------------------------------------------
   // energization counter has no clear path; reset is power-up only
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         energize_hrs <= '0;
         energize_wrap_count <= '0;
      end else if (HOUR_TICK_I) begin
         energize_hrs <= energize_hrs + 16'h0001;
         if (energize_hrs == 16'hffff) begin
            energize_wrap_count <= energize_wrap_count + 16'h0001;
         end
      end
   end

   // run_full stays set only if running never dropped since last tick
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         run_full <= 1'b0;
      end else if (!RUNNING_I) begin
         run_full <= 1'b0;
      end else if (HOUR_TICK_I) begin
         run_full <= 1'b1;
      end
   end

   // run counter; a clear in the same cycle as a tick wins
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         run_hrs <= '0;
         runtime_wrap_count <= '0;
      end else if (wr_rtclr_zero) begin
         run_hrs <= '0;
      end else if (HOUR_TICK_I && RUNNING_I && run_full) begin
         run_hrs <= run_hrs + 16'h0001;
         if (run_hrs == 16'hffff) begin
            runtime_wrap_count <= runtime_wrap_count + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // display formatting
   // ------------------------------------------------------------
   logic [23:0] next_disp_v;
   logic [1:0] next_disp_f;
   logic [23:0] next_pu_v;
   logic [1:0] next_pu_f;

   // energy step changes with magnitude on both panel widths
   always_comb begin
      next_pu_v = '0;
      next_pu_f = 2'h0;
      if (energy_rep <= `DMON_E_5D2) begin
         next_pu_v = energy_rep[23:0];
         next_pu_f = 2'h2;
      end else if (energy_rep <= `DMON_E_5D1) begin
         next_pu_v = 24'((energy_rep / 32'h0000_000a));
         next_pu_f = 2'h1;
      end else begin
         next_pu_v = (energy_rep / 32'h0000_0064 > {8'h00, `DMON_E_5MAX}) ?
                     `DMON_E_5MAX : 24'((energy_rep / 32'h0000_0064));
      end
   end

   // selected value; accumulators bypass the decimal selection
   always_comb begin
      next_disp_v = MON_VALUE_I;
      next_disp_f = MON_FRAC_I;
      unique case (monitor_select)
         `DMON_SEL_ENHRS: begin
            next_disp_v = {8'h00, energize_hrs};
            next_disp_f = 2'h0;
         end
         `DMON_SEL_RNHRS: begin
            next_disp_v = {8'h00, run_hrs};
            next_disp_f = 2'h0;
         end
         `DMON_SEL_ENERGY: begin
            if (energy_rep <= `DMON_E_4D2) begin
               next_disp_v = energy_rep[23:0];
               next_disp_f = 2'h2;
            end else if (energy_rep <= `DMON_E_4D1) begin
               next_disp_v = 24'((energy_rep / 32'h0000_000a));
               next_disp_f = 2'h1;
            end else begin
               next_disp_f = 2'h0;
               next_disp_v = (energy_rep / 32'h0000_0064 > {8'h00, `DMON_E_4MAX}) ?
                             `DMON_E_4MAX : 24'((energy_rep / 32'h0000_0064));
            end
         end
         default: begin
            if (decimal_digit_select == `DMON_V_ZERO && MON_FRAC_I == 2'h1) begin
               // round, but anything under 0.99 is forced to zero
               next_disp_v = (MON_VALUE_I < 24'h00000a) ? 24'h0 :
                             (MON_VALUE_I + 24'h000005) / 24'h00000a;
               next_disp_f = 2'h0;
            end else if (decimal_digit_select == `DMON_V_ZERO &&
                         MON_FRAC_I == 2'h2) begin
               next_disp_v = (MON_VALUE_I < 24'h000063) ? 24'h0 :
                             (MON_VALUE_I + 24'h000032) / 24'h000064;
               next_disp_f = 2'h0;
            end else if (decimal_digit_select == `DMON_V_ONE &&
                         MON_FRAC_I == 2'h2) begin
               next_disp_v = MON_VALUE_I / 24'h00000a;
               next_disp_f = 2'h1;
            end
         end
      endcase
   end

   // display data registered to keep the panel glitch free
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         DISP_VALUE_O <= '0;
         DISP_FRAC_O <= 2'h0;
         PU_VALUE_O <= '0;
         PU_FRAC_O <= 2'h0;
      end else begin
         DISP_VALUE_O <= next_disp_v;
         DISP_FRAC_O <= next_disp_f;
         PU_VALUE_O <= next_pu_v;
         PU_FRAC_O <= next_pu_f;
      end
   end

   // ------------------------------------------------------------
   // terminal monitor
   // ------------------------------------------------------------
   dmon_seg_t next_seg;
   logic next_term;

   // option data ignored when the option is absent
   always_comb begin
      next_seg = '0;
      next_term = 1'b1;
      unique case (monitor_select)
         `DMON_SEL_TERM: next_seg = seg_map(IN_TERM_I, OUT_TERM_I, 2'b00);
         `DMON_SEL_OPTIN: next_seg = seg_map(
            OPT_IN_FIT_I ? OPT_IN_TERM_I[11:0] : 12'h000,
            OPT_IN_FIT_I ? OPT_IN_TERM_I[23:12] : 12'h000, 2'b01);
         `DMON_SEL_OPTOUT: next_seg = seg_map(
            OPT_OUT_FIT_I ? OPT_OUT_TERM_I[11:0] : 12'h000,
            OPT_OUT_FIT_I ? OPT_OUT_TERM_I[23:12] : 12'h000, 2'b10);
         default: next_term = 1'b0;
      endcase
   end

   // segment pattern for the third monitor position
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         SEG_O <= '0;
         TERM_MON_O <= 1'b0;
      end else begin
         SEG_O <= next_seg;
         TERM_MON_O <= next_term;
      end
   end

   // ------------------------------------------------------------
   // meter output
   // ------------------------------------------------------------
   // divider is wide; registered once so the path has a full cycle
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         METER_O <= '0;
      end else if (meter_src) begin
         METER_O <= scale(CURRENT_I, current_fullscale_ref);
      end else begin
         METER_O <= scale(FREQ_I, freq_fullscale_ref);
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_meter_ceiling:
   assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      METER_O <= `DMON_METER_FS) else $error("meter above full scale");

   a_freq_full:
   assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (!meter_src && FREQ_I == freq_fullscale_ref && FREQ_I != 16'h0000)
      |=> METER_O == `DMON_METER_FS) else $error("meter not full at reference");

   a_enclr_zero:
   assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      wr_enclr_zero |=> energy_acc == 32'h0 && energy_rep == 32'h0)
      else $error("energy not cleared");

   a_enclr_read:
   assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      energy_clear_param == `DMON_V_NOFUNC || energy_clear_param == `DMON_V_TEN)
      else $error("energy clear reads bad value");

   a_runclr_zero:
   assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      wr_rtclr_zero |=> run_hrs == 16'h0000) else $error("run hours not cleared");

   a_run_hold:
   assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      !RUNNING_I && !wr_rtclr_zero |=> $stable(run_hrs))
      else $error("run hours moved while stopped");

   a_energize_wrap:
   assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      HOUR_TICK_I && energize_hrs == 16'hffff |=> energize_hrs == 16'h0000 &&
      energize_wrap_count == $past(energize_wrap_count) + 16'h0001)
      else $error("energize wrap miscounted");

   a_energize_tick:
   assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      HOUR_TICK_I |=> energize_hrs == $past(energize_hrs) + 16'h0001)
      else $error("energize hour missed");

   a_term_centre:
   assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      TERM_MON_O |-> SEG_O[6] && SEG_O[14] && SEG_O[22] && SEG_O[30])
      else $error("centre row dark");

   a_optin_absent:
   assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      monitor_select == `DMON_SEL_OPTIN && !OPT_IN_FIT_I |=>
      (SEG_O & 32'h3f3f3f3f) == 32'h0 && SEG_O[7]) else $error("absent option lit");
endmodule
`default_nettype wire

// file: testbench/dmon_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// parameter access port of the panel side
// ----------------------------------------
module dmon_host (
   // clock
   input wire logic clk_i,
   // apb master
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [7:0] paddr_o,
   output logic [31:0] pwdata_o,
   input wire logic pready_i,
   input wire logic [31:0] prdata_i,
   input wire logic pslverr_i
);
   // bus idle from time zero
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0;
   end
   // request held until pready is seen; answer taken at that same edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic err);
      @(posedge clk_i);
      psel_o <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clk_i);
      penable_o <= 1'b1;
      do @(posedge clk_i); while (pready_i !== 1'b1);
      q = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
   endtask
   // clearing is only ever a write of zero from this side
   task automatic clear(input logic [7:0] a);
      logic [31:0] q;
      logic e;
      xfer(1'b1, a, 32'h0, q, e);
   endtask
endmodule
`default_nettype wire

// file: testbench/drive_monitor_accumulators_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmon_params.svh"
module drive_monitor_accumulators_tb;
   logic clk = 1'b0, rst = 1'b1, tick = 1'b0, run = 1'b0, ifit = 1'b0, ofit = 1'b0;
   logic [15:0] pwr = 16'h0, frq = 16'h0, cur = 16'h0;
   logic [11:0] it = 12'h0, ot = 12'h0;
   logic [23:0] oi = 24'h0, oo = 24'h0;
   logic [23:0] mv = 24'h0;
   logic [1:0] mf = 2'h0;
   logic [23:0] dv, pv;
   logic [1:0] df, pf;
   logic psel, pen, pwrite, prdy, perr, term;
   logic [7:0] padr;
   logic [31:0] pwd, prd, seg;
   logic [9:0] mtr;
   int n_mismatch = 0, checks = 0;
   // ----------------------------------------
   // clock, dut and host
   // ----------------------------------------
   always #5 clk = ~clk;
   dmon_monitor u_dut (.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwrite), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
      .PSLVERR_O(perr), .HOUR_TICK_I(tick), .RUNNING_I(run), .POWER_I(pwr), .FREQ_I(frq),
      .CURRENT_I(cur), .MON_VALUE_I(mv), .MON_FRAC_I(mf), .IN_TERM_I(it),
      .OUT_TERM_I(ot), .OPT_IN_FIT_I(ifit), .OPT_IN_TERM_I(oi), .OPT_OUT_FIT_I(ofit),
      .OPT_OUT_TERM_I(oo), .SEG_O(seg), .TERM_MON_O(term), .DISP_VALUE_O(dv),
      .DISP_FRAC_O(df), .PU_VALUE_O(pv), .PU_FRAC_O(pf), .METER_O(mtr));
   dmon_host u_host (.clk_i(clk), .psel_o(psel), .penable_o(pen), .pwrite_o(pwrite),
      .paddr_o(padr), .pwdata_o(pwd), .pready_i(prdy), .prdata_i(prd), .pslverr_i(perr));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      u_host.xfer(1'b1, a, d, q, e);
      repeat (2) @(posedge clk); // monitors follow one cycle later
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      u_host.xfer(1'b0, a, 32'h0, q, e);
      chk(nm, q, exp);
   endtask
   task automatic hour();
      @(posedge clk) tick <= 1'b1;
      @(posedge clk) tick <= 1'b0;
   endtask
   // segment byte is {dp,g,f,e,d,c,b,a}; a,b,f from upper source, c,d,e lower
   function automatic logic [31:0] segx(logic [11:0] u, logic [11:0] l, logic [3:0] dp);
      logic [31:0] s;
      for (int d = 0; d < 4; d++) begin
         s[8*d+:8] = {dp[d], 1'b1, u[3*d+2], l[3*d+2], l[3*d+1], l[3*d], u[3*d+1], u[3*d]};
      end
      return s;
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_terminals();
      it <= 12'ha5c;
      ot <= 12'h3e1;
      oi <= 24'h5a_3c96;
      wr(`DMON_A_MONSEL, 32'd55);
      chk("term", {31'h0, term}, 32'h1);
      chk("seg55", seg, segx(12'ha5c, 12'h3e1, 4'h0));
      wr(`DMON_A_MONSEL, 32'd56);
      chk("seg56 bare", seg & 32'h3f3f_3f3f, 32'h0);
      ifit <= 1'b1;
      repeat (2) @(posedge clk);
      chk("seg56", seg, segx(12'hc96, 12'h5a3, 4'h1));
      ofit <= 1'b1;
      oo <= 24'h0f0_00f;
      wr(`DMON_A_MONSEL, 32'd57);
      chk("seg57", seg, segx(12'h00f, 12'h0f0, 4'h2));
      wr(`DMON_A_MONSEL, 32'd25);
      chk("term off", {31'h0, term}, 32'h0);
      $display("terminal monitor done");
   endtask
   task automatic t_energy();
      pwr <= 16'd1234;
      hour();
      hour();
      rd("energy", `DMON_A_ENRAW, 32'd2468);
      rd("energy kwh", `DMON_A_ENCOM, 32'd24);
      wr(`DMON_A_ENCLR, 32'd10);
      u_host.clear(`DMON_A_ENCLR);
      rd("energy cleared", `DMON_A_ENRAW, 32'd0);
      rd("enclr read", `DMON_A_ENCLR, 32'd10);
      $display("energy done");
   endtask
   task automatic t_hours();
      run <= 1'b1;
      hour();
      hour();
      hour();
      rd("run hours", `DMON_A_RNHRS, 32'd2);
      run <= 1'b0;
      hour();
      rd("run held", `DMON_A_RNHRS, 32'd2);
      rd("energize", `DMON_A_ENHRS, 32'd6);
      wr(`DMON_A_RTCLR, 32'd9999);
      rd("run kept", `DMON_A_RNHRS, 32'd2);
      u_host.clear(`DMON_A_RTCLR);
      rd("run zero", `DMON_A_RNHRS, 32'd0);
      rd("energize kept", `DMON_A_ENHRS, 32'd6);
      rd("rtclr read", `DMON_A_RTCLR, 32'd9999);
      $display("hour counters done");
   endtask
   task automatic t_meter();
      rd("fref", `DMON_A_FREF, 32'd5000);
      frq <= 16'd2500;
      wr(`DMON_A_MSRC, 32'd0);
      chk("meter half", {22'h0, mtr}, 32'd500);
      frq <= 16'd6000;
      repeat (2) @(posedge clk);
      chk("meter sat", {22'h0, mtr}, 32'd1000);
      frq <= 16'd5000;
      repeat (2) @(posedge clk);
      chk("meter full", {22'h0, mtr}, 32'd1000);
      cur <= 16'd250;
      wr(`DMON_A_MSRC, 32'd1);
      wr(`DMON_A_CREF, 32'd1000);
      chk("meter cur", {22'h0, mtr}, 32'd250);
      $display("meter done");
   endtask
   // energy is 49.36 kWh here; selection 25 is still active from the terminal test
   task automatic t_display();
      chk("pu energy", {6'h0, pf, pv}, {8'h02, 24'd4936});
      chk("disp energy", {6'h0, df, dv}, {8'h02, 24'd4936});
      wr(`DMON_A_DECSEL, 32'd0);
      chk("energy dec0", {6'h0, df, dv}, {8'h02, 24'd4936});
      mv <= 24'd1234;
      mf <= 2'h2;
      wr(`DMON_A_MONSEL, 32'd0);
      chk("round", {6'h0, df, dv}, 32'd12);
      mv <= 24'd98;
      repeat (2) @(posedge clk);
      chk("below one", {6'h0, df, dv}, 32'd0);
      mv <= 24'd1234;
      wr(`DMON_A_DECSEL, 32'd1);
      chk("tenths", {6'h0, df, dv}, {8'h01, 24'd123});
      mf <= 2'h0;
      repeat (2) @(posedge clk);
      chk("integer", {6'h0, df, dv}, 32'd1234);
      $display("display done");
   endtask
   // tick held high: first tick arms the run counter, then 65536 hours wrap both
   task automatic t_wrap();
      run <= 1'b1;
      tick <= 1'b1;
      repeat (65537) @(posedge clk);
      tick <= 1'b0;
      run <= 1'b0;
      rd("energize wrapped", `DMON_A_ENHRS, 32'd7);
      rd("energize wraps", `DMON_A_ENWRP, 32'd1);
      rd("run wrapped", `DMON_A_RNHRS, 32'd0);
      rd("run wraps", `DMON_A_RNWRP, 32'd1);
      $display("wrap done");
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd("enclr rst", `DMON_A_ENCLR, 32'd9999);
      t_terminals();
      t_energy();
      t_hours();
      t_meter();
      t_display();
      t_wrap();
      summarize();
   end
   // the wrap test dominates: about 66000 cycles for the whole run
   initial begin
      repeat (80000) @(posedge clk);
      n_mismatch++;
      summarize();
   end
endmodule
`default_nettype wire
